// ===== inc/wwd_pkg.sv
// Constants, types and helpers shared by the window watchdog design files.
// Behaviour
// - Timeout length comes from the low six counter bits, the programmed count.
// - Timebase select picks prescaler phase pair: 4/59, 8/53, 20/35, 49/54.
// - Minimum timeout: (phase+128)*64 base, 16384 per count, some steps (192+phase)*64.
// - Maximum timeout: 16384 base plus 16384 per count, same short-step adjustment.
// - All divisions in the timeout arithmetic truncate toward the lower integer.
// - Wait mode leaves the watchdog untouched; the downcounter keeps decrementing.
// - Plain halt: counter decrements once, then stops, no reset until wakeup.
// - Wakeup from halt by interrupt resumes counting after 256 or 4096 clocks.
// - Reset out of halt leaves watchdog disabled unless hardware option set.
// - Halt with halt-reset option and no oscillator interrupt causes a reset.
// - Halt with oscillator interrupt enabled enters active halt; counting stops.
// - In active halt an oscillator or external interrupt restarts counting at once.
// - In active halt a reset restarts counting after 256 or 4096 clocks.
// - Hardware option keeps the watchdog always active, activation bit ignored.
// - Active watchdog resets when the counter rolls from 40h to 3Fh.
// - Active or activating reload while the counter exceeds the window value causes a reset.
// - Software activation bit stays set until a reset clears it.
package wwd_pkg;
	// Clock and oscillator timing.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned OSC2_PERIOD_NS = 125;
	localparam int unsigned OSC_DIV = (OSC2_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);
	// Prescaler: a full step is 256 units, a short step 192 plus phase units.
	localparam int unsigned PRESC_UNIT_DEF = 64;
	localparam int unsigned FULL_MULT = 256;
	localparam int unsigned SHORT_MULT_BASE = 192;
	localparam logic [6:0] STEP_INC = 7'h04;
	// Startup delay after wakeup or reset, in CPU clocks.
	localparam int unsigned STARTUP_SHORT = 256;
	localparam int unsigned STARTUP_LONG = 4096;
	localparam logic [12:0] STARTUP_SHORT_LAST = 13'(STARTUP_SHORT - 1);
	localparam logic [12:0] STARTUP_LONG_LAST = 13'(STARTUP_LONG - 1);
	// Register indices; the byte address is four times the index.
	localparam logic [15:0] IDX_CONTROL = 16'h002A;
	localparam logic [15:0] IDX_WINDOW = 16'h002B;
	localparam logic [15:0] IDX_STATUS = 16'h002C;
	// Field layout and reset values.
	localparam int unsigned ACT_BIT = 7;
	localparam int unsigned GUARD_BIT = 6;
	localparam logic [7:0] CTRL_RST = 8'h7F;
	localparam logic [6:0] WIN_RST = 7'h7F;
	localparam logic [5:0] COUNT_ZERO = 6'h00;
	// Status register bit positions.
	localparam int unsigned ST_ACTIVE = 0;
	localparam int unsigned ST_RUN = 1;
	localparam int unsigned ST_HALTED = 2;
	localparam int unsigned ST_STARTUP = 3;
	localparam int unsigned ST_HW_OPT = 4;
	localparam int unsigned ST_HALT_RST = 5;
	localparam int unsigned ST_LONG = 6;

	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_HALT_ONE,
		MODE_HALTED,
		MODE_ACT_HALT,
		MODE_STARTUP
	} wwd_mode_t;

	function automatic logic [15:0] reg_addr(input logic [15:0] idx);
		return {idx[13:0], 2'b00};
	endfunction

	// Upper phase value per timebase (4, 8, 20, 49).
	function automatic logic [5:0] tb_msb(input logic [1:0] tb);
		unique case (tb)
			2'b00: return 6'h04;
			2'b01: return 6'h08;
			2'b10: return 6'h14;
			2'b11: return 6'h31;
		endcase
	endfunction

	// Lower phase value per timebase (59, 53, 35, 54).
	function automatic logic [5:0] tb_lsb(input logic [1:0] tb);
		unique case (tb)
			2'b00: return 6'h3B;
			2'b01: return 6'h35;
			2'b10: return 6'h23;
			2'b11: return 6'h36;
		endcase
	endfunction
endpackage

// ===== hw/wwd_presc.sv
// Free-running oscillator divider and watchdog prescaler.
`timescale 1ns/1ns
module wwd_presc #(
	parameter int unsigned PRESC_UNIT = wwd_pkg::PRESC_UNIT_DEF
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Control.
	input wire logic [1:0] timebase_select,
	input wire logic restart,
	// Decrement strobe.
	output logic dec_tick
);
	import wwd_pkg::*;

	typedef struct packed {
		logic [3:0] div;
		logic [14:0] cnt;
		logic [6:0] acc;
		logic tick;
	} wwd_presc_st_t;

	wwd_presc_st_t s_q;
	wwd_presc_st_t s_d;
	logic osc_tick;
	logic step_short;
	logic [6:0] acc_next;
	logic [6:0] msb7;
	logic [14:0] last;

	function automatic logic [14:0] period_last(input logic shrt, input logic [5:0] lsb);
		int unsigned mult;
		mult = shrt ? SHORT_MULT_BASE + int'(lsb) : FULL_MULT;
		return 15'(mult * PRESC_UNIT - 1);
	endfunction

	always_comb begin
		s_d = s_q;
		osc_tick = (s_q.div == OSC_DIV_LAST);
		msb7 = {1'b0, tb_msb(timebase_select)};
		// The accumulator tracks floor(4*steps/msb) with no divider: a step is
		// short each time the running quotient advances.
		acc_next = s_q.acc + STEP_INC;
		step_short = (acc_next >= msb7);
		last = period_last(step_short, tb_lsb(timebase_select));
		s_d.tick = 1'b0;
		s_d.div = osc_tick ? 4'h0 : s_q.div + 4'h1;
		if (osc_tick) begin
			// The phase is never cleared by a write, hence the min/max spread.
			if (s_q.cnt >= last) begin
				s_d.cnt = 15'h0000;
				s_d.tick = 1'b1;
				s_d.acc = step_short ? acc_next - msb7 : acc_next;
			end else begin
				s_d.cnt = s_q.cnt + 15'h0001;
			end
		end
		if (restart) begin
			s_d.acc = 7'h00;
		end
		if (reset) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	assign dec_tick = s_q.tick;

	acc_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
		s_q.acc < {1'b0, tb_msb(timebase_select)})
		else $error("Prescaler accumulator not below the phase value.");
	restart_clr_a: assert property (@(posedge clk_sys) disable iff (reset)
		restart |=> s_q.acc == 7'h00)
		else $error("Prescaler step count not cleared by a reload.");
endmodule // wwd_presc

// ===== hw/wwd_apb.sv
// APB slave front end for the watchdog registers.
`timescale 1ns/1ns
module wwd_apb (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Register side.
	output logic wr_ctrl,
	output logic wr_win,
	output logic [7:0] wdata,
	input wire logic [7:0] ctrl_rd,
	input wire logic [7:0] win_rd,
	input wire logic [7:0] stat_rd
);
	import wwd_pkg::*;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [7:0] rdata;
	} wwd_apb_st_t;

	wwd_apb_st_t s_q;
	wwd_apb_st_t s_d;
	logic access;

	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// Read data is captured in the setup cycle so every APB output stays registered
		// with no wait state: pready is high in the first access cycle.
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			if (paddr == reg_addr(IDX_CONTROL)) begin
				s_d.rdata = ctrl_rd;
			end else if (paddr == reg_addr(IDX_WINDOW)) begin
				s_d.rdata = win_rd;
			end else if (paddr == reg_addr(IDX_STATUS)) begin
				s_d.rdata = stat_rd;
			end else begin
				s_d.rdata = 8'h00;
				s_d.pslverr = 1'b1;
			end
		end
		if (reset) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	assign access = psel && penable && s_q.pready && pwrite;
	assign wr_ctrl = access && (paddr == reg_addr(IDX_CONTROL));
	assign wr_win = access && (paddr == reg_addr(IDX_WINDOW));
	assign wdata = pwdata[7:0];
	assign prdata = {24'h00_0000, s_q.rdata};
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;

	apb_ready_a: assert property (@(posedge clk_sys) disable iff (reset)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("APB ready not a single cycle after setup.");
endmodule // wwd_apb

// ===== hw/wwd_top.sv
// Window watchdog core: downcounter, window check, low-power modes, register bus.
`timescale 1ns/1ns
module wwd_top #(
	parameter int unsigned PRESC_UNIT = wwd_pkg::PRESC_UNIT_DEF
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// APB register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Main clock controller settings.
	input wire logic [1:0] timebase_select,
	input wire logic osc_int_enable,
	// Option straps, caught while reset is held.
	input wire logic hw_watchdog_option,
	input wire logic halt_reset_option,
	input wire logic startup_long_option,
	// CPU power events.
	input wire logic cpu_halt,
	input wire logic ext_irq,
	input wire logic osc_irq,
	// Reset request to the reset controller.
	output logic wd_reset_req
);
	import wwd_pkg::*;

	typedef struct packed {
		logic activation_bit;
		logic [6:0] count;
		logic [6:0] window;
		wwd_mode_t mode;
		logic [12:0] startup_cnt;
		logic hw_opt;
		logic halt_rst_opt;
		logic long_opt;
		logic rst_req;
	} wwd_core_st_t;

	wwd_core_st_t s_q;
	wwd_core_st_t s_d;
	logic dec_tick;
	logic wr_ctrl;
	logic wr_win;
	logic [7:0] wdata;
	logic [7:0] ctrl_rd;
	logic [7:0] win_rd;
	logic [7:0] stat_rd;
	logic active;
	logic act_after_wr;
	logic [5:0] programmed_count;
	logic guard_roll;
	logic [12:0] startup_last;

	wwd_apb u_apb (
		.clk_sys(clk_sys),
		.reset(reset),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wr_ctrl(wr_ctrl),
		.wr_win(wr_win),
		.wdata(wdata),
		.ctrl_rd(ctrl_rd),
		.win_rd(win_rd),
		.stat_rd(stat_rd)
	);

	wwd_presc #(
		.PRESC_UNIT(PRESC_UNIT)
	) u_presc (
		.clk_sys(clk_sys),
		.reset(reset),
		.timebase_select(timebase_select),
		.restart(wr_ctrl),
		.dec_tick(dec_tick)
	);

	assign active = s_q.hw_opt || s_q.activation_bit;
	assign act_after_wr = active || wdata[ACT_BIT];
	assign programmed_count = s_q.count[5:0];
	// The guard bit falls on the decrement taken with the low six bits at zero.
	assign guard_roll = s_q.count[GUARD_BIT] && (programmed_count == COUNT_ZERO);
	assign startup_last = s_q.long_opt ? STARTUP_LONG_LAST : STARTUP_SHORT_LAST;

	assign ctrl_rd = {s_q.activation_bit, s_q.count};
	assign win_rd = {1'b0, s_q.window};

	always_comb begin
		stat_rd = 8'h00;
		stat_rd[ST_ACTIVE] = active;
		stat_rd[ST_RUN] = (s_q.mode == MODE_RUN);
		stat_rd[ST_HALTED] = (s_q.mode == MODE_HALT_ONE) || (s_q.mode == MODE_HALTED)
			|| (s_q.mode == MODE_ACT_HALT);
		stat_rd[ST_STARTUP] = (s_q.mode == MODE_STARTUP);
		stat_rd[ST_HW_OPT] = s_q.hw_opt;
		stat_rd[ST_HALT_RST] = s_q.halt_rst_opt;
		stat_rd[ST_LONG] = s_q.long_opt;
	end

	always_comb begin
		s_d = s_q;
		s_d.rst_req = 1'b0;
		// Slow and wait modes only change the CPU clock; this counter runs from the
		// oscillator prescaler, so nothing here looks at them.
		unique case (s_q.mode)
			MODE_RUN: begin
				if (dec_tick) begin
					s_d.count = s_q.count - 7'h01;
					if (guard_roll && active) begin
						s_d.rst_req = 1'b1;
					end
				end
				if (cpu_halt) begin
					if (osc_int_enable) begin
						s_d.mode = MODE_ACT_HALT;
					end else if (s_q.halt_rst_opt) begin
						s_d.rst_req = 1'b1;
					end else begin
						s_d.mode = MODE_HALT_ONE;
					end
				end
			end
			MODE_HALT_ONE: begin
				// One last decrement, with its reset suppressed since the part is halted.
				if (dec_tick) begin
					s_d.count = s_q.count - 7'h01;
					s_d.mode = MODE_HALTED;
				end
			end
			MODE_HALTED: begin
				if (ext_irq) begin
					s_d.mode = MODE_STARTUP;
					s_d.startup_cnt = 13'h0000;
				end
			end
			MODE_ACT_HALT: begin
				if (osc_irq || ext_irq) begin
					s_d.mode = MODE_RUN;
				end
			end
			MODE_STARTUP: begin
				if (s_q.startup_cnt == startup_last) begin
					s_d.mode = MODE_RUN;
				end else begin
					s_d.startup_cnt = s_q.startup_cnt + 13'h0001;
				end
			end
		endcase
		// A reload overrides a decrement taken in the same cycle.
		if (wr_ctrl) begin
			s_d.count = wdata[6:0];
			s_d.activation_bit = s_q.activation_bit || wdata[ACT_BIT];
			if (act_after_wr && (s_q.count > s_q.window)) begin
				s_d.rst_req = 1'b1;
			end
			if (act_after_wr && !wdata[GUARD_BIT]) begin
				s_d.rst_req = 1'b1;
			end
		end
		if (wr_win) begin
			s_d.window = wdata[6:0];
		end
		if (reset) begin
			s_d.activation_bit = CTRL_RST[ACT_BIT];
			s_d.count = CTRL_RST[6:0];
			s_d.window = WIN_RST;
			s_d.mode = MODE_STARTUP;
			s_d.startup_cnt = 13'h0000;
			s_d.rst_req = 1'b0;
			// Straps are sampled on every clocked edge while reset is held.
			s_d.hw_opt = hw_watchdog_option;
			s_d.halt_rst_opt = halt_reset_option;
			s_d.long_opt = startup_long_option;
		end
	end

	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	// The block has no interrupt; the reset request is its only system effect.
	assign wd_reset_req = s_q.rst_req;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_plain_halt;
		cpu_halt && (s_q.mode == MODE_RUN) && !osc_int_enable && !s_q.halt_rst_opt
			&& !wr_ctrl && !(dec_tick && guard_roll && active);
	endsequence
	sequence s_one_step;
		(s_q.mode == MODE_HALT_ONE) && !wd_reset_req;
	endsequence
	sequence s_wake_ext;
		(s_q.mode == MODE_HALTED) && ext_irq;
	endsequence
	sequence s_startup_begin;
		(s_q.mode == MODE_STARTUP) && (s_q.startup_cnt == 13'h0000);
	endsequence

	guard_roll_a: assert property (
		((s_q.mode == MODE_RUN) && active && dec_tick && guard_roll && !wr_ctrl)
		|=> wd_reset_req && (s_q.count[GUARD_BIT] == 1'b0))
		else $error("No reset on guard bit roll-over.");
	early_reload_a: assert property (
		(wr_ctrl && act_after_wr && (s_q.count > s_q.window))
		|=> wd_reset_req && (s_q.count == $past(wdata[6:0])))
		else $error("Early reload did not request a reset.");
	act_sticky_a: assert property (
		s_q.activation_bit |=> s_q.activation_bit)
		else $error("Activation bit cleared without reset.");
	halt_reset_a: assert property (
		(cpu_halt && (s_q.mode == MODE_RUN) && !osc_int_enable && s_q.halt_rst_opt)
		|=> wd_reset_req && (s_q.mode == MODE_RUN))
		else $error("Halt with reset option did not reset.");
	plain_halt_a: assert property (
		s_plain_halt |=> s_one_step)
		else $error("Plain halt did not take the single decrement step.");
	halted_frozen_a: assert property (
		((s_q.mode == MODE_HALTED) && !wr_ctrl) |=> $stable(s_q.count) && !wd_reset_req)
		else $error("Counter moved or reset while halted.");
	act_halt_freeze_a: assert property (
		((s_q.mode == MODE_ACT_HALT) && !wr_ctrl) |=> $stable(s_q.count) && !wd_reset_req)
		else $error("Counter moved in active halt.");
	act_halt_wake_a: assert property (
		((s_q.mode == MODE_ACT_HALT) && (osc_irq || ext_irq)) |=> (s_q.mode == MODE_RUN))
		else $error("Active halt wakeup did not resume counting at once.");
	halt_wake_a: assert property (
		s_wake_ext |=> s_startup_begin)
		else $error("Halt wakeup did not start the startup delay.");
	startup_end_a: assert property (
		((s_q.mode == MODE_STARTUP) && (s_q.startup_cnt == startup_last))
		|=> (s_q.mode == MODE_RUN) ##1 (s_q.mode != MODE_STARTUP))
		else $error("Startup delay did not end on its last count.");
	startup_hold_a: assert property (
		((s_q.mode == MODE_STARTUP) && (s_q.startup_cnt != startup_last) && !wr_ctrl)
		|=> (s_q.mode == MODE_STARTUP) && $stable(s_q.count) && !wd_reset_req)
		else $error("Counting resumed before the startup delay ended.");
	hw_active_a: assert property (
		(s_q.hw_opt && (s_q.mode == MODE_RUN) && dec_tick && guard_roll && !wr_ctrl)
		|=> wd_reset_req)
		else $error("Hardware option did not force the watchdog active.");
endmodule // wwd_top

// ===== bench/tb_top.sv
// Self-checking bench for the window watchdog core.
`timescale 1ns/1ns
module tb_top;
	import wwd_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} wwd_note_t;
	localparam logic [15:0] A_CTL = IDX_CONTROL << 2;
	localparam logic [15:0] A_WIN = IDX_WINDOW << 2;
	localparam logic [15:0] A_ST = IDX_STATUS << 2;
	localparam int MSBS[4] = '{4, 8, 20, 49};
	localparam int LSBS[4] = '{59, 53, 35, 54};
	localparam logic [2:0] EV_HALT = 3'h4;
	localparam logic [2:0] EV_EXT = 3'h2;
	localparam logic [2:0] EV_OSC = 3'h1;
	logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, wd_reset_req;
	logic [1:0] timebase_select = 2'h0;
	logic osc_int_enable = 0, hw_watchdog_option = 0, halt_reset_option = 0;
	logic startup_long_option = 0, cpu_halt = 0, ext_irq = 0, osc_irq = 0;
	logic [7:0] lfsr = 8'h34;
	int mismatches = 0, total_checks = 0, cyc = 0, c;
	wwd_note_t note;
	wwd_note_t rd_q[$];
	int lo_q[$], hi_q[$];

	// A scaled-down prescaler unit keeps a full decrement step at 3328 clocks.
	wwd_top #(.PRESC_UNIT(1)) dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .timebase_select, .osc_int_enable,
		.hw_watchdog_option, .halt_reset_option, .startup_long_option, .cpu_halt,
		.ext_irq, .osc_irq, .wd_reset_req);

	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	function automatic logic [7:0] nxt(input logic [7:0] l);
		return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
	endfunction

	// Timeout in oscillator ticks, minimum when mx is 0 and maximum when 1.
	function automatic int t_osc(input int cnt, input int msb, input int lsb, input bit mx);
		int q;
		q = 4 * cnt / msb;
		if (mx ? cnt <= msb / 4 : cnt < msb / 4) return (mx ? 256 : lsb + 128) + 256 * cnt;
		return (mx ? 256 : lsb + 128) + 256 * (cnt - q) + (192 + lsb) * q;
	endfunction

	task automatic check_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_time(input string what, input int lo, input int hi, input int seen);
		total_checks++;
		if (seen < lo || seen > hi) begin
			mismatches++;
			$display("[ERR] %s expected cycle %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1) begin
			if (rd_q.size() == 0) check_bus("apb_extra", 32'h0000_0001, 32'h0000_0000);
			else begin
				note = rd_q.pop_front();
				check_bus("prdata", note.d, prdata & note.m);
				check_bus("pslverr", {31'h0, note.e}, {31'h0, pslverr});
			end
		end
		if (wd_reset_req === 1'b1) begin
			if (lo_q.size() == 0) check_time("wd_reset_req", 0, -1, cyc);
			else check_time("wd_reset_req", lo_q.pop_front(), hi_q.pop_front(), cyc);
		end
	end

	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		rd_q.push_back('{w ? 32'h0 : d & m, w ? 32'h0 : m, e});
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1, a, {24'h0, d}, 32'h0, 0);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] m);
		bus(0, a, d, m, 0);
	endtask

	task automatic do_reset(input logic hw, input logic hr, input logic lg);
		@(posedge clk_sys);
		reset <= 1;
		hw_watchdog_option <= hw;
		halt_reset_option <= hr;
		startup_long_option <= lg;
		repeat (8) @(posedge clk_sys);
		reset <= 0;
	endtask

	// Raises the chosen CPU event lines {cpu_halt, ext_irq, osc_irq} for one cycle.
	task automatic pulse(input logic [2:0] ev);
		{cpu_halt, ext_irq, osc_irq} <= ev;
		@(posedge clk_sys);
		{cpu_halt, ext_irq, osc_irq} <= 3'h0;
	endtask

	// Notes a reset request window relative to now and waits for it to be seen.
	task automatic expect_rst(input int lo, input int hi);
		lo_q.push_back(cyc + lo);
		hi_q.push_back(cyc + hi);
		repeat (hi + 4) if (lo_q.size() != 0) @(posedge clk_sys);
		if (lo_q.size() != 0) begin
			check_time("wd_reset_req", lo, hi, -1);
			void'(lo_q.pop_front());
			void'(hi_q.pop_front());
		end
	endtask

	initial begin
		#800000;
		mismatches++;
		wrap_up();
	end

	initial begin
		do_reset(0, 0, 1);
		rd(A_ST, 32'h0000_0048, 32'h0000_0048);
		rd(A_CTL, 32'h0000_007F, 32'h0000_00FF);
		rd(A_WIN, 32'h0000_007F, 32'h0000_00FF);
		bus(0, 16'h0100, 32'h0, 32'hFFFF_FFFF, 1);
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			wr(A_WIN, lfsr);
			rd(A_WIN, {25'h0, lfsr[6:0]}, 32'hFFFF_FFFF);
		end
		do_reset(0, 0, 0);
		wr(A_CTL, 8'hFF);
		wr(A_CTL, 8'h7F);
		rd(A_CTL, 32'h0000_0080, 32'h0000_0080);
		wr(A_WIN, 8'h50);
		wr(A_CTL, 8'hFF);
		expect_rst(0, 4);
		do_reset(0, 0, 0);
		wr(A_CTL, 8'hBF);
		expect_rst(0, 4);
		do_reset(1, 0, 0);
		wr(A_CTL, 8'h40);
		expect_rst(0, 3620);
		do_reset(0, 1, 0);
		repeat (300) @(posedge clk_sys);
		pulse(EV_HALT);
		expect_rst(0, 4);
		do_reset(0, 0, 0);
		repeat (300) @(posedge clk_sys);
		wr(A_CTL, 8'h7F);
		pulse(EV_HALT);
		repeat (4000) @(posedge clk_sys);
		rd(A_CTL, 32'h0000_007E, 32'h0000_007F);
		repeat (4000) @(posedge clk_sys);
		rd(A_CTL, 32'h0000_007E, 32'h0000_007F);
		pulse(EV_EXT);
		repeat (3700) @(posedge clk_sys);
		rd(A_CTL, 32'h0000_007D, 32'h0000_007F);
		// Activate before halting so that the reset out of halt has something to clear.
		wr(A_CTL, 8'hFF);
		pulse(EV_HALT);
		repeat (20) @(posedge clk_sys);
		// A reset out of halt must leave the counter unable to request a reset.
		do_reset(0, 0, 0);
		wr(A_CTL, 8'h40);
		repeat (4000) @(posedge clk_sys);
		osc_int_enable <= 1;
		wr(A_CTL, 8'h7F);
		pulse(EV_HALT);
		repeat (4000) @(posedge clk_sys);
		rd(A_CTL, 32'h0000_007F, 32'h0000_007F);
		pulse(EV_OSC);
		repeat (3400) @(posedge clk_sys);
		rd(A_CTL, 32'h0000_007E, 32'h0000_007F);
		osc_int_enable <= 0;
		for (int t = 0; t < 4; t++) begin
			timebase_select <= 2'(t);
			do_reset(0, 0, 0);
			repeat (300) @(posedge clk_sys);
			lfsr = nxt(lfsr);
			c = lfsr[1:0];
			wr(A_CTL, 8'hC0 | 8'(c));
			expect_rst(t_osc(c, MSBS[t], LSBS[t], 0) * 13 - 13,
				t_osc(c, MSBS[t], LSBS[t], 1) * 13 + 26);
		end
		repeat (20) @(posedge clk_sys);
		check_bus("notes_left", 32'h0, 32'(rd_q.size() + lo_q.size()));
		wrap_up();
	end
endmodule // tb_top
